// *** hw/ctf_framer.sv ***
// What this block does
// [R1] packet nests data link, network, transport and logical layers
// [R2] one framing for synchronous and asynchronous links; only padding differs
// [R3] each frame carries one payload field: packet, padding, or both
// [R4] payload field fills exactly the configured length of characters; the code does so on synchronous links only
// [R5] on synchronous links the configured length should stay constant
// [R6] packet overhead is 32 characters; length must exceed 32; the code flags short lengths on synchronous links only
// [R7] lengths above 256 characters are invalid on both link types
// [R8] synchronous links pad remaining positions after packet or empty frame
// [R9] asynchronous links send packets when ready without padding
// [R10] link packet: start, network packet, four checksum characters, end
// [R11] network packet: source address, separator, destination, separator, transport
// [R12] transport fields: sequence, acknowledge, repetition, validity, flag, separated
// [R13] logical message characters pass through unchanged
// [R14] start is line feed; end and padding are carriage return
// [R15] checksum is four hex characters over network packet characters
// [R16] receiver drops packets missing end or failing checksum
// [R17] separators are single space characters
// [R18] byte-wide valid/ready streams plus a frame start strobe
// [R19] length loads only between frames; synchronous range errors flagged
`timescale 1ns/1ps
`default_nettype none

module ctf_framer
	import ctf_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// configuration
	input wire logic [8:0] CFG_LENGTH,
	input wire logic CFG_SYNC,
	input wire logic CFG_LOAD,
	output logic LEN_ERROR,
	// frame timing and packet request
	input wire logic FRAME_START,
	input wire logic PKT_VALID,
	output logic PKT_SENT,
	output logic BUSY,
	// header fields, stable from frame start until packet sent
	input wire logic [15:0] SRC_ADDR,
	input wire logic [15:0] DST_ADDR,
	input wire logic [23:0] SEQ_CHARS,
	input wire logic [23:0] ACK_CHARS,
	input wire logic [7:0] REP_CHAR,
	input wire logic [7:0] ACKV_CHAR,
	input wire logic [23:0] FLAG_CHARS,
	// logical message in
	input wire logic MSG_VALID,
	input wire logic [7:0] MSG_DATA,
	input wire logic MSG_LAST,
	output logic MSG_READY,
	// payload field out
	output logic OUT_VALID,
	output logic [7:0] OUT_DATA,
	output logic OUT_FIRST,
	output logic OUT_LAST,
	input wire logic OUT_READY,
	// payload field in, receive check
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_FRAME_END,
	output logic RX_PKT_GOOD,
	output logic RX_PKT_BAD,
	output logic [8:0] RX_PKT_LEN
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// bit-serial crc, msb first
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] ch);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ ch[i]) begin
				r = {r[14:0], 1'b0} ^ CTF_CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction : crc_upd

	// nibble to upper-case hex character
	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		logic [7:0] w;
		w = {4'h0, n};
		if (n < CTF_HEX_DIGITS) begin
			return CTF_CHAR_ZERO + w;
		end
		return CTF_HEX_ALPHA_OFS + w;
	endfunction : hex_chr

	////////////////////////////////////////////////////////////////////////////
	// configuration

	logic [8:0] len_q, len_d;
	logic sync_q, sync_d;
	logic err_q, err_d;
	ctf_tx_e tx_q, tx_d;

	// length may change only while idle, so a running frame keeps its size
	always_comb begin
		len_d = len_q;
		sync_d = sync_q;
		if (CFG_LOAD && tx_q == CTF_TX_IDLE) begin // R19 R5
			len_d = CFG_LENGTH;
			sync_d = CFG_SYNC;
		end
		err_d = (len_d > CTF_MAX_LEN) || (sync_d && len_d <= CTF_OVERHEAD); // R6 R7 R19
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			len_q <= CTF_MAX_LEN;
			sync_q <= 1'b1;
			err_q <= 1'b0;
		end else begin
			len_q <= len_d;
			sync_q <= sync_d;
			err_q <= err_d;
		end
	end

	assign LEN_ERROR = err_q;

	////////////////////////////////////////////////////////////////////////////
	// header characters, start through last separator

	logic [8*CTF_HDR_LEN-1:0] hdr_vec;

	assign hdr_vec = {CTF_CHAR_START, // R14 R10 R1
		hex_chr(SRC_ADDR[15:12]), hex_chr(SRC_ADDR[11:8]), // R11
		hex_chr(SRC_ADDR[7:4]), hex_chr(SRC_ADDR[3:0]), CTF_CHAR_SEP, // R17
		hex_chr(DST_ADDR[15:12]), hex_chr(DST_ADDR[11:8]),
		hex_chr(DST_ADDR[7:4]), hex_chr(DST_ADDR[3:0]), CTF_CHAR_SEP,
		SEQ_CHARS, CTF_CHAR_SEP, ACK_CHARS, CTF_CHAR_SEP, // R12
		REP_CHAR, CTF_CHAR_SEP, ACKV_CHAR, CTF_CHAR_SEP,
		FLAG_CHARS, CTF_CHAR_SEP};

	////////////////////////////////////////////////////////////////////////////
	// transmit sequencer

	logic [4:0] idx_q, idx_d;
	logic [8:0] pos_q, pos_d;
	logic [15:0] crc_q, crc_d;
	logic first_q, first_d;
	logic ov_q, ov_d;
	logic [7:0] od_q, od_d;
	logic of_q, of_d;
	logic ol_q, ol_d;
	logic adv, emit, is_end;
	logic [7:0] ch;
	logic [8:0] pos_nx;

	assign adv = !ov_q || OUT_READY; // R18
	assign pos_nx = pos_q + 9'h001;

	always_comb begin
		tx_d = tx_q;
		idx_d = idx_q;
		pos_d = pos_q;
		crc_d = crc_q;
		first_d = first_q;
		ov_d = adv ? 1'b0 : ov_q;
		od_d = od_q;
		of_d = adv ? 1'b0 : of_q;
		ol_d = adv ? 1'b0 : ol_q;
		emit = 1'b0;
		is_end = 1'b0;
		ch = CTF_CHAR_PAD;
		MSG_READY = 1'b0;
		PKT_SENT = 1'b0;
		unique case (tx_q)
			CTF_TX_IDLE: begin
				// a strobe with an invalid length is dropped; nothing is sent
				// a strobe meeting a load is dropped too, else the frame runs unchecked
				if (FRAME_START && !err_q && !CFG_LOAD) begin // R3 R19
					pos_d = '0;
					first_d = 1'b1;
					idx_d = '0;
					crc_d = CTF_CRC_INIT;
					if (PKT_VALID) begin
						tx_d = CTF_TX_HEAD;
					end else if (sync_q) begin
						tx_d = CTF_TX_PAD; // R8
					end
				end
			end
			CTF_TX_HEAD: begin
				if (adv) begin
					emit = 1'b1;
					ch = hdr_vec[8*(CTF_HDR_LEN-1-int'(idx_q)) +: 8];
					if (idx_q != '0) begin
						crc_d = crc_upd(crc_q, ch); // R15
					end
					idx_d = idx_q + 5'h01;
					if (idx_q == CTF_HDR_LAST) begin
						tx_d = CTF_TX_BODY;
					end
				end
			end
			CTF_TX_BODY: begin
				// a message longer than the room left is cut; rest stays queued
				if (pos_q >= len_q - CTF_TAIL_LEN) begin // R4
					tx_d = CTF_TX_CHECK;
					idx_d = '0;
				end else begin
					MSG_READY = adv;
					if (adv && MSG_VALID) begin
						emit = 1'b1;
						ch = MSG_DATA; // R13
						crc_d = crc_upd(crc_q, ch);
						if (MSG_LAST) begin
							tx_d = CTF_TX_CHECK;
							idx_d = '0;
						end
					end
				end
			end
			CTF_TX_CHECK: begin
				if (adv) begin
					emit = 1'b1;
					ch = hex_chr(crc_q[4*(3-int'(idx_q[1:0])) +: 4]); // R10 R15
					idx_d = idx_q + 5'h01;
					if (idx_q[1:0] == CTF_CRC_LAST) begin
						tx_d = CTF_TX_STOP;
					end
				end
			end
			CTF_TX_STOP: begin
				if (adv) begin
					emit = 1'b1;
					is_end = 1'b1;
					ch = CTF_CHAR_END; // R14
					PKT_SENT = 1'b1;
					// asynchronous links end the field with the packet
					if (sync_q && pos_nx != len_q) begin
						tx_d = CTF_TX_PAD; // R8
					end else begin
						tx_d = CTF_TX_IDLE; // R9
					end
				end
			end
			CTF_TX_PAD: begin
				if (adv) begin
					emit = 1'b1;
					ch = CTF_CHAR_PAD; // R14
					if (pos_nx == len_q) begin
						tx_d = CTF_TX_IDLE; // R4
					end
				end
			end
		endcase
		if (emit) begin
			ov_d = 1'b1;
			od_d = ch;
			of_d = first_q;
			first_d = 1'b0;
			ol_d = sync_q ? (pos_nx == len_q) : is_end; // R2
			pos_d = pos_nx;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_q <= CTF_TX_IDLE;
			idx_q <= '0;
			pos_q <= '0;
			crc_q <= CTF_CRC_INIT;
			first_q <= 1'b0;
			ov_q <= 1'b0;
			od_q <= 8'h00;
			of_q <= 1'b0;
			ol_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			idx_q <= idx_d;
			pos_q <= pos_d;
			crc_q <= crc_d;
			first_q <= first_d;
			ov_q <= ov_d;
			od_q <= od_d;
			of_q <= of_d;
			ol_q <= ol_d;
		end
	end

	assign OUT_VALID = ov_q;
	assign OUT_DATA = od_q;
	assign OUT_FIRST = of_q;
	assign OUT_LAST = ol_q;
	assign BUSY = (tx_q != CTF_TX_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// receive check

	ctf_rx_e rx_q, rx_d;
	logic [8:0] cnt_q, cnt_d;
	logic [15:0] rcrc_q, rcrc_d;
	logic [15:0] hist_q [CTF_CRC_CHARS];
	logic [15:0] hist_d [CTF_CRC_CHARS];
	logic [7:0] tail_q [CTF_CRC_CHARS];
	logic [7:0] tail_d [CTF_CRC_CHARS];
	logic [15:0] rx_sum;
	logic [CTF_CRC_CHARS-1:0] tail_ok;
	logic good_q, good_d, bad_q, bad_d;
	logic [8:0] rlen_q, rlen_d;
	logic shift;

	// decode the last four characters as the received checksum
	genvar g;
	generate
		for (g = 0; g < CTF_CRC_CHARS; g++) begin : g_dec
			logic [7:0] c;
			assign c = tail_q[g];
			assign tail_ok[g] = (c >= CTF_CHAR_ZERO && c <= CTF_CHAR_NINE) ||
				(c >= CTF_CHAR_UA && c <= CTF_CHAR_UF);
			assign rx_sum[CTF_NIB_W*g +: CTF_NIB_W] = (c <= CTF_CHAR_NINE) ?
				c[3:0] : 4'(c - CTF_HEX_ALPHA_OFS);
			// history and tail shift together, newest at entry zero
			if (g == 0) begin : g_head
				always_comb begin
					hist_d[g] = shift ? rcrc_q : hist_q[g];
					tail_d[g] = shift ? RX_DATA : tail_q[g];
				end
			end else begin : g_tail
				// a generate branch, so entry zero never names a neighbour below it
				always_comb begin
					hist_d[g] = shift ? hist_q[g-1] : hist_q[g];
					tail_d[g] = shift ? tail_q[g-1] : tail_q[g];
				end
			end
			always_ff @(posedge CLK or posedge RESET) begin
				if (RESET) begin
					hist_q[g] <= CTF_CRC_INIT;
					tail_q[g] <= 8'h00;
				end else begin
					hist_q[g] <= hist_d[g];
					tail_q[g] <= tail_d[g];
				end
			end
		end
	endgenerate

	// frame end outranks a character in the same cycle
	always_comb begin
		rx_d = rx_q;
		cnt_d = cnt_q;
		rcrc_d = rcrc_q;
		rlen_d = rlen_q;
		good_d = 1'b0;
		bad_d = 1'b0;
		shift = 1'b0;
		unique case (rx_q)
			CTF_RX_HUNT: begin
				if (RX_VALID && RX_DATA == CTF_CHAR_START) begin
					rx_d = CTF_RX_IN;
					cnt_d = 9'h001;
					rcrc_d = CTF_CRC_INIT;
				end
			end
			CTF_RX_IN: begin
				if (RX_FRAME_END) begin
					bad_d = 1'b1; // R16
					rx_d = CTF_RX_HUNT;
				end else if (RX_VALID) begin
					cnt_d = cnt_q + 9'h001;
					if (RX_DATA == CTF_CHAR_END) begin
						rlen_d = cnt_d;
						rx_d = CTF_RX_HUNT;
						if (cnt_d >= CTF_OVERHEAD && (&tail_ok) &&
							hist_q[CTF_CRC_CHARS-1] == rx_sum) begin // R16
							good_d = 1'b1;
						end else begin
							bad_d = 1'b1;
						end
					end else if (cnt_d >= CTF_MAX_LEN) begin
						bad_d = 1'b1; // R7
						rx_d = CTF_RX_HUNT;
					end else begin
						shift = 1'b1;
						rcrc_d = crc_upd(rcrc_q, RX_DATA);
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rx_q <= CTF_RX_HUNT;
			cnt_q <= '0;
			rcrc_q <= CTF_CRC_INIT;
			rlen_q <= '0;
			good_q <= 1'b0;
			bad_q <= 1'b0;
		end else begin
			rx_q <= rx_d;
			cnt_q <= cnt_d;
			rcrc_q <= rcrc_d;
			rlen_q <= rlen_d;
			good_q <= good_d;
			bad_q <= bad_d;
		end
	end

	assign RX_PKT_GOOD = good_q;
	assign RX_PKT_BAD = bad_q;
	assign RX_PKT_LEN = rlen_q;

endmodule : ctf_framer

`default_nettype wire

// *** hw/ctf_pkg.sv ***
package ctf_pkg;

	// character codes on the link
	localparam logic [7:0] CTF_CHAR_START = 8'h0A;
	localparam logic [7:0] CTF_CHAR_END = 8'h0D;
	localparam logic [7:0] CTF_CHAR_PAD = 8'h0D;
	localparam logic [7:0] CTF_CHAR_SEP = 8'h20;
	localparam logic [7:0] CTF_CHAR_ZERO = 8'h30;
	localparam logic [7:0] CTF_CHAR_NINE = 8'h39;
	localparam logic [7:0] CTF_CHAR_UA = 8'h41;
	localparam logic [7:0] CTF_CHAR_UF = 8'h46;
	localparam logic [7:0] CTF_HEX_ALPHA_OFS = 8'h37;
	localparam logic [3:0] CTF_HEX_DIGITS = 4'hA;

	// field geometry, in characters; CTF_LEN_W and CTF_NIB_W are bit widths
	localparam int CTF_LEN_W = 9;
	localparam logic [8:0] CTF_OVERHEAD = 9'h020;
	localparam logic [8:0] CTF_MAX_LEN = 9'h100;
	localparam int CTF_HDR_LEN = 27;
	localparam logic [4:0] CTF_HDR_LAST = 5'h1A;
	localparam logic [1:0] CTF_CRC_LAST = 2'h3;
	localparam logic [8:0] CTF_TAIL_LEN = 9'h005;
	localparam int CTF_CRC_CHARS = 4;
	localparam int CTF_NIB_W = 4;

	// checksum, polynomial and preset
	localparam logic [15:0] CTF_CRC_POLY = 16'h1021;
	localparam logic [15:0] CTF_CRC_INIT = 16'hFFFF;

	typedef enum logic [2:0] {
		CTF_TX_IDLE,
		CTF_TX_HEAD,
		CTF_TX_BODY,
		CTF_TX_CHECK,
		CTF_TX_STOP,
		CTF_TX_PAD
	} ctf_tx_e;

	typedef enum logic {
		CTF_RX_HUNT,
		CTF_RX_IN
	} ctf_rx_e;

endpackage : ctf_pkg

// *** dv/ctf_framer_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module ctf_framer_chk
	import ctf_pkg::*;
(
	// clock, reset, configuration
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [8:0] CFG_LENGTH,
	input wire logic CFG_SYNC,
	input wire logic CFG_LOAD,
	input wire logic LEN_ERROR,
	// framing
	input wire logic FRAME_START,
	input wire logic PKT_VALID,
	input wire logic PKT_SENT,
	input wire logic BUSY,
	input wire logic OUT_VALID,
	input wire logic [7:0] OUT_DATA,
	input wire logic OUT_FIRST,
	input wire logic OUT_LAST,
	input wire logic OUT_READY,
	input wire logic RX_PKT_GOOD,
	input wire logic RX_PKT_BAD
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	////////////////////////////////////////////////////////////////
	property p_len_high;
		CFG_LOAD && !BUSY && CFG_LENGTH > CTF_MAX_LEN |=> LEN_ERROR;
	endproperty
	a_len_high: assert property (p_len_high) else $error("long length not flagged");
	property p_len_low;
		CFG_LOAD && !BUSY && CFG_SYNC && CFG_LENGTH <= CTF_OVERHEAD |=> LEN_ERROR;
	endproperty
	a_len_low: assert property (p_len_low) else $error("short length not flagged");
	property p_len_ok;
		CFG_LOAD && !BUSY && CFG_LENGTH > CTF_OVERHEAD && CFG_LENGTH <= CTF_MAX_LEN |=> !LEN_ERROR;
	endproperty
	a_len_ok: assert property (p_len_ok) else $error("legal length flagged");
	property p_cfg_frozen;
		BUSY |=> $stable(LEN_ERROR);
	endproperty
	a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed in frame");
	property p_hold;
		OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST);
	endproperty
	a_hold: assert property (p_hold) else $error("output char not held");
	property p_start;
		FRAME_START && PKT_VALID && !BUSY && !LEN_ERROR && !OUT_VALID && !CFG_LOAD
			|-> ##[2:3] (OUT_VALID && OUT_FIRST && OUT_DATA == CTF_CHAR_START);
	endproperty
	a_start: assert property (p_start) else $error("packet not opened by start char");
	property p_end;
		PKT_SENT |=> OUT_VALID && OUT_DATA == CTF_CHAR_END;
	endproperty
	a_end: assert property (p_end) else $error("end char missing");
	property p_fall;
		$fell(BUSY) |-> OUT_VALID && OUT_LAST;
	endproperty
	a_fall: assert property (p_fall) else $error("field ended without last char");
	property p_rx_one;
		RX_PKT_GOOD || RX_PKT_BAD |-> !(RX_PKT_GOOD && RX_PKT_BAD) ##1 (!RX_PKT_GOOD && !RX_PKT_BAD);
	endproperty
	a_rx_one: assert property (p_rx_one) else $error("packet both good and bad");
endmodule : ctf_framer_chk

bind ctf_framer ctf_framer_chk chk (.CLK(CLK), .RESET(RESET), .CFG_LENGTH(CFG_LENGTH),
	.CFG_SYNC(CFG_SYNC), .CFG_LOAD(CFG_LOAD), .LEN_ERROR(LEN_ERROR),
	.FRAME_START(FRAME_START), .PKT_VALID(PKT_VALID), .PKT_SENT(PKT_SENT), .BUSY(BUSY),
	.OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_FIRST(OUT_FIRST), .OUT_LAST(OUT_LAST),
	.OUT_READY(OUT_READY), .RX_PKT_GOOD(RX_PKT_GOOD), .RX_PKT_BAD(RX_PKT_BAD));

`default_nettype wire

// *** dv/ctf_peer.sv ***
`timescale 1ns/1ps
`default_nettype none

module ctf_peer (
	// control
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [1:0] BAD,
	// field from the framer
	input wire logic OUT_VALID,
	input wire logic [7:0] OUT_DATA,
	input wire logic OUT_FIRST,
	input wire logic OUT_LAST,
	output logic OUT_READY,
	// field looped back to the receiver
	output logic RX_VALID,
	output logic [7:0] RX_DATA,
	output logic RX_FRAME_END
);
	logic acc;
	logic fe_q;
	int cnt_q;
	assign acc = OUT_VALID && OUT_READY;

	////////////////////////////////////////////////////////////////
	// random stalls; idle data inverted so stale chars never look valid
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			OUT_READY <= 1'b0;
			RX_VALID <= 1'b0;
			RX_DATA <= 8'h00;
			RX_FRAME_END <= 1'b0;
			fe_q <= 1'b0;
			cnt_q <= 0;
		end else begin
			OUT_READY <= ($urandom % 4) != 0;
			RX_VALID <= acc;
			// bit one hides every carriage return, so the packet never ends in its frame
			if (acc && BAD[1] && OUT_DATA == 8'h0D) RX_DATA <= 8'h2E;
			else RX_DATA <= acc ? OUT_DATA ^ {7'h00, BAD[0] && cnt_q == 1} : ~RX_DATA;
			cnt_q <= acc ? (OUT_FIRST ? 1 : cnt_q + 1) : cnt_q;
			fe_q <= acc && OUT_LAST;
			RX_FRAME_END <= fe_q;
		end
	end
endmodule : ctf_peer

`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ctf_pkg::*;
	logic CLK = 0, RESET = 1, CFG_SYNC = 1, CFG_LOAD = 0, FRAME_START = 0, PKT_VALID = 0;
	logic MSG_VALID = 0, MSG_LAST = 0, fst = 0;
	logic [1:0] bad = 2'h0;
	logic [8:0] CFG_LENGTH = 9'h100;
	logic [15:0] SRC_ADDR = 0, DST_ADDR = 0;
	logic [23:0] SEQ_CHARS = 0, ACK_CHARS = 0, FLAG_CHARS = 24'h585858;
	logic [7:0] REP_CHAR = 0, ACKV_CHAR = 8'h53, MSG_DATA = 0, OUT_DATA, RX_DATA;
	logic LEN_ERROR, PKT_SENT, BUSY, MSG_READY, OUT_VALID, OUT_FIRST, OUT_LAST, OUT_READY;
	logic RX_VALID, RX_FRAME_END, RX_PKT_GOOD, RX_PKT_BAD;
	logic [8:0] RX_PKT_LEN;
	int err_total = 0, cmp_count = 0, goods = 0, bads = 0;
	logic [7:0] exq[$], msq[$], nq[$];

	always #4 CLK = ~CLK;

	ctf_framer uut (.CLK, .RESET, .CFG_LENGTH, .CFG_SYNC, .CFG_LOAD, .LEN_ERROR, .FRAME_START,
		.PKT_VALID, .PKT_SENT, .BUSY, .SRC_ADDR, .DST_ADDR, .SEQ_CHARS, .ACK_CHARS, .REP_CHAR,
		.ACKV_CHAR, .FLAG_CHARS, .MSG_VALID, .MSG_DATA, .MSG_LAST, .MSG_READY, .OUT_VALID,
		.OUT_DATA, .OUT_FIRST, .OUT_LAST, .OUT_READY, .RX_VALID, .RX_DATA, .RX_FRAME_END,
		.RX_PKT_GOOD, .RX_PKT_BAD, .RX_PKT_LEN);
	ctf_peer peer (.CLK, .RESET, .BAD(bad), .OUT_VALID, .OUT_DATA, .OUT_FIRST, .OUT_LAST,
		.OUT_READY, .RX_VALID, .RX_DATA, .RX_FRAME_END);

	////////////////////////////////////////////////////////////////
	task end_sim;
		$display("mismatches %0d of %0d compares", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task chk(logic [15:0] got, logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	function logic [7:0] hx(logic [3:0] n);
		return n < 4'hA ? 8'h30 + n : 8'h37 + n;
	endfunction : hx

	function logic [15:0] crc(logic [15:0] c, logic [7:0] b);
		for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CTF_CRC_POLY : 16'h0000);
		return c;
	endfunction : crc

	// monitor and message source; stream changes 1 ns after the edge
	always @(posedge CLK) begin
		if (OUT_VALID && OUT_READY) begin
			if (exq.size() == 0) chk(16'h0001, 16'h0000);
			else chk(OUT_DATA, exq.pop_front());
			chk(OUT_LAST, exq.size() == 0);
			chk(OUT_FIRST, fst);
			fst = 0;
		end
		if (MSG_VALID && MSG_READY) void'(msq.pop_front());
		goods += RX_PKT_GOOD;
		bads += RX_PKT_BAD;
		#1 MSG_VALID = msq.size() > 0;
		MSG_DATA = msq.size() ? msq[0] : ~MSG_DATA;
		MSG_LAST = msq.size() == 1;
	end

	task cfg(int len, bit sy, bit e);
		@(posedge CLK);
		#1 CFG_LENGTH = len[8:0];
		CFG_SYNC = sy;
		CFG_LOAD = 1;
		@(posedge CLK);
		#1 CFG_LOAD = 0;
		chk(LEN_ERROR, e);
	endtask : cfg

	// one frame: expected field built from the layer rules
	task run(int len, bit sy, bit pv, int n, logic [1:0] bd);
		int m, pl, g0, b0;
		logic [15:0] c, a;
		cfg(len, sy, 0);
		SRC_ADDR = $urandom;
		DST_ADDR = $urandom;
		SEQ_CHARS = {hx(4'($urandom % 10)), 16'h3037};
		ACK_CHARS = {16'h3031, hx(4'($urandom % 10))};
		REP_CHAR = hx(4'($urandom % 10));
		bad = bd;
		fst = 1;
		g0 = goods;
		b0 = bads;
		m = n < len - 32 ? n : len - 32;
		nq = {};
		msq = {};
		for (int i = 0; i < 2; i++) begin
			a = i ? DST_ADDR : SRC_ADDR;
			for (int j = 3; j >= 0; j--) nq.push_back(hx(a[4 * j +: 4]));
			nq.push_back(CTF_CHAR_SEP);
		end
		foreach (nq[i]) exq.push_back(nq[i]);
		nq = {SEQ_CHARS[23:16], SEQ_CHARS[15:8], SEQ_CHARS[7:0], CTF_CHAR_SEP, ACK_CHARS[23:16],
			ACK_CHARS[15:8], ACK_CHARS[7:0], CTF_CHAR_SEP, REP_CHAR, CTF_CHAR_SEP, ACKV_CHAR,
			CTF_CHAR_SEP, FLAG_CHARS[23:16], FLAG_CHARS[15:8], FLAG_CHARS[7:0], CTF_CHAR_SEP};
		nq = {exq, nq};
		exq = {};
		for (int i = 0; i < n; i++) msq.push_back(8'h21 + 8'($urandom % 94));
		for (int i = 0; i < m; i++) nq.push_back(msq[i]);
		c = CTF_CRC_INIT;
		foreach (nq[i]) c = crc(c, nq[i]);
		exq = {CTF_CHAR_START, nq, hx(c[15:12]), hx(c[11:8]), hx(c[7:4]), hx(c[3:0]), CTF_CHAR_END};
		pl = exq.size();
		if (!pv) begin
			exq = {};
			msq = {};
		end
		while (sy && exq.size() < len) exq.push_back(CTF_CHAR_PAD);
		@(posedge CLK);
		#1 FRAME_START = 1;
		PKT_VALID = pv;
		@(posedge CLK);
		#1 FRAME_START = 0;
		chk(BUSY, exq.size() > 0);
		if (exq.size()) begin
			CFG_LENGTH = 9'h1FF;
			CFG_LOAD = 1;
			repeat (3) @(posedge CLK);
			#1 CFG_LOAD = 0;
		end
		for (int i = 0; i < 3000 && exq.size(); i++) @(posedge CLK);
		repeat (6) @(posedge CLK);
		chk(16'(exq.size()), 0);
		chk(LEN_ERROR, 0);
		chk(16'(goods - g0), pv && !bd);
		chk(16'(bads - b0), pv && bd);
		if (pv && !bd) chk(RX_PKT_LEN, 16'(pl));
		msq = {};
	endtask : run

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(54181));
		repeat (8) @(posedge CLK);
		#1 RESET = 0;
		cfg(32, 1, 1);
		cfg(33, 1, 0);
		cfg(257, 1, 1);
		cfg(20, 0, 0);
		cfg(300, 0, 1);
		@(posedge CLK);
		#1 FRAME_START = 1;
		PKT_VALID = 1;
		@(posedge CLK);
		#1 FRAME_START = 0;
		chk(BUSY, 0);
		run(40, 1, 1, 3, 0);
		run(40, 1, 1, 20, 0);
		run(33, 1, 1, 1, 0);
		run(256, 1, 1, 50, 0);
		run(256, 0, 1, 10, 0);
		run(100, 0, 1, 5, 1);
		run(40, 1, 1, 3, 2'h2);
		run(40, 1, 0, 0, 0);
		run(40, 0, 0, 0, 0);
		// a strobe meeting a load must not start a frame
		@(posedge CLK);
		#1 FRAME_START = 1;
		PKT_VALID = 1;
		CFG_LOAD = 1;
		@(posedge CLK);
		#1 FRAME_START = 0;
		CFG_LOAD = 0;
		chk(BUSY, 0);
		chk(LEN_ERROR, 0);
		repeat (4) @(posedge CLK);
		end_sim();
	end

	// watchdog
	initial begin
		#400000;
		err_total++;
		end_sim();
	end
endmodule : testbench

`default_nettype wire
